// file: include/cmul_pkg.sv
package cmul_pkg;

  typedef enum {CMUL_PLAIN, CMUL_STREAM, CMUL_STREAM_FC} cmul_variant_t;

  localparam int CMUL_MIN_W = 1;
  localparam int CMUL_MAX_W = 1024;
  localparam int CMUL_DEF_W = 16;
  localparam int CMUL_MAX_LANES = 64;
  localparam int CMUL_DEF_LANES = 1;
  localparam int CMUL_MAX_USER_W = 8;
  localparam int CMUL_DEF_USER_W = 1;
  localparam int CMUL_SIGNED_TRIM = 1;
  localparam int CMUL_PLAIN_LAT = 1;
  localparam int CMUL_STREAM_LAT = 1;
  localparam int CMUL_FC_LAT = 4;
  localparam int CMUL_FIFO_DEPTH = 16;
  localparam int CMUL_RUN_W = 4;

  function automatic int cmul_clamp(input int v, input int lo, input int hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : cmul_clamp

  function automatic int cmul_prod_w(input int aw, input int bw,
                                     input bit sa, input bit sb);
    if (sa && sb) begin
      return aw + bw - CMUL_SIGNED_TRIM;
    end
    return aw + bw;
  endfunction : cmul_prod_w

  function automatic int cmul_out_w(input int ow, input int pw);
    return cmul_clamp(cmul_clamp(ow, CMUL_MIN_W, CMUL_MAX_W), CMUL_MIN_W, pw);
  endfunction : cmul_out_w

  function automatic int cmul_latency(input cmul_variant_t v, input bit latch,
                                      input bit pipe);
    int lat;
    lat = CMUL_PLAIN_LAT;
    case (v)
      CMUL_PLAIN: lat = CMUL_PLAIN_LAT + int'(latch);
      CMUL_STREAM: lat = CMUL_STREAM_LAT;
      CMUL_STREAM_FC: lat = CMUL_FC_LAT;
      default: lat = CMUL_PLAIN_LAT;
    endcase
    return lat + int'(pipe);
  endfunction : cmul_latency

endpackage : cmul_pkg

// file: design/cmul_fifo.sv
`timescale 1ns/1ps
module cmul_fifo
  import cmul_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int PTR_W = $clog2(DEPTH),
  localparam int CNT_W = PTR_W + 1
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level.
  output logic [CNT_W-1:0] count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != CNT_W'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];
  assign count = cnt_r;
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = wr_r + PTR_W'(1);
    end
    if (pop) begin
      rd_nxt = rd_r + PTR_W'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage is not reset; the count guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

endmodule : cmul_fifo

// file: design/cmul_top.sv
`timescale 1ns/1ps
module cmul_top
  import cmul_pkg::*;
#(
  parameter cmul_variant_t VARIANT = CMUL_PLAIN,
  parameter int A_W = CMUL_DEF_W,
  parameter int B_W = CMUL_DEF_W,
  parameter bit A_SGN = 1'b0,
  parameter bit B_SGN = 1'b0,
  parameter int OUT_W = CMUL_DEF_W,
  parameter int LANES = CMUL_DEF_LANES,
  parameter int USER_W = CMUL_DEF_USER_W,
  parameter bit LATCH_IN = 1'b0,
  parameter bit PIPE = 1'b0,
  localparam int AW = cmul_clamp(A_W, CMUL_MIN_W, CMUL_MAX_W),
  localparam int BW = cmul_clamp(B_W, CMUL_MIN_W, CMUL_MAX_W),
  localparam int SS = cmul_clamp(LANES, CMUL_MIN_W, CMUL_MAX_LANES),
  localparam int UW = cmul_clamp(USER_W, CMUL_MIN_W, CMUL_MAX_USER_W),
  localparam int PW = cmul_prod_w(AW, BW, A_SGN, B_SGN),
  localparam int OW = cmul_out_w(OUT_W, PW)
) (
  // Clock, reset and freeze.
  input wire logic MCLK,
  input wire logic ACTIVE_LOW_RESET,
  input wire logic CE,
  // Operand A stream.
  input wire logic [SS*AW-1:0] A_TDATA,
  input wire logic A_TVALID,
  output logic A_TREADY,
  input wire logic A_TLAST,
  input wire logic [UW-1:0] A_TUSER,
  // Operand B stream.
  input wire logic [SS*BW-1:0] B_TDATA,
  input wire logic B_TVALID,
  output logic B_TREADY,
  // Product stream.
  output logic [SS*OW-1:0] DOUT_TDATA,
  output logic DOUT_TVALID,
  input wire logic DOUT_TREADY,
  output logic DOUT_TLAST,
  output logic [UW-1:0] DOUT_TUSER
);

  localparam bit IS_FC = VARIANT == CMUL_STREAM_FC;
  localparam int LAT = cmul_latency(VARIANT, LATCH_IN, PIPE);
  // Stages before the result leaves the line; the FIFO adds one more.
  localparam int NST = IS_FC ? LAT - 1 : LAT;
  localparam int MS = (IS_FC || (VARIANT == CMUL_PLAIN && LATCH_IN)) ? 1 : 0;
  localparam int RL = NST - MS;
  localparam int DW = SS * OW;
  localparam int FW = DW + 1 + UW;
  localparam int FCW = $clog2(CMUL_FIFO_DEPTH) + 1;
  localparam logic [AW-1:0] A_MIN = ~({AW{1'b1}} >> 1);
  localparam logic [BW-1:0] B_MIN = ~({BW{1'b1}} >> 1);
  localparam logic [PW-1:0] SAT_P = {PW{1'b1}} >> 1;
  localparam logic [OW-1:0] SAT_TOP = SAT_P[PW-1 -: OW];

  logic in_fire, room;
  logic [SS*AW-1:0] op_a;
  logic [SS*BW-1:0] op_b;
  logic op_v, op_l;
  logic [UW-1:0] op_u;
  logic [FCW-1:0] op_cnt, infl, fifo_cnt;
  logic [DW-1:0] prod;
  logic [DW-1:0] res_d_r [RL];
  logic [DW-1:0] res_d_nxt [RL];
  logic [RL-1:0] res_v_r, res_v_nxt, res_l_r, res_l_nxt;
  logic [UW-1:0] res_u_r [RL];
  logic [UW-1:0] res_u_nxt [RL];
  logic end_v, end_l;
  logic [UW-1:0] end_u;
  logic [DW-1:0] end_d;
  logic fifo_in_ready;

  // Operands join: the stream variants take a beat only when both sides offer one; plain takes one at every enabled edge.
  always_comb begin
    case (VARIANT)
      CMUL_PLAIN: begin
        in_fire = CE;
        A_TREADY = CE;
        B_TREADY = CE;
      end
      CMUL_STREAM: begin
        in_fire = CE && A_TVALID && B_TVALID;
        A_TREADY = CE && B_TVALID;
        B_TREADY = CE && A_TVALID;
      end
      CMUL_STREAM_FC: begin
        in_fire = CE && A_TVALID && B_TVALID && room;
        A_TREADY = CE && B_TVALID && room;
        B_TREADY = CE && A_TVALID && room;
      end
      default: begin
        in_fire = 1'b0;
        A_TREADY = 1'b0;
        B_TREADY = 1'b0;
      end
    endcase
  end

  generate
    if (MS == 1) begin : g_latch
      logic [SS*AW-1:0] op_a_r, op_a_nxt;
      logic [SS*BW-1:0] op_b_r, op_b_nxt;
      logic op_v_r, op_v_nxt, op_l_r, op_l_nxt;
      logic [UW-1:0] op_u_r, op_u_nxt;
      always_comb begin
        op_a_nxt = A_TDATA;
        op_b_nxt = B_TDATA;
        op_v_nxt = in_fire;
        op_l_nxt = A_TLAST;
        op_u_nxt = A_TUSER;
      end
      always_ff @(posedge MCLK or negedge ACTIVE_LOW_RESET) begin
        if (!ACTIVE_LOW_RESET) begin
          op_a_r <= '0;
          op_b_r <= '0;
          op_v_r <= 1'b0;
          op_l_r <= 1'b0;
          op_u_r <= '0;
        end else if (CE) begin
          op_a_r <= op_a_nxt;
          op_b_r <= op_b_nxt;
          op_v_r <= op_v_nxt;
          op_l_r <= op_l_nxt;
          op_u_r <= op_u_nxt;
        end
      end
      assign op_a = op_a_r;
      assign op_b = op_b_r;
      assign op_v = op_v_r;
      assign op_l = op_l_r;
      assign op_u = op_u_r;
      assign op_cnt = FCW'(op_v_r);
    end else begin : g_direct
      assign op_a = A_TDATA;
      assign op_b = B_TDATA;
      assign op_v = in_fire;
      assign op_l = A_TLAST;
      assign op_u = A_TUSER;
      assign op_cnt = '0;
    end
  endgenerate

  // One independent multiplier per lane.
  for (genvar l = 0; l < SS; l++) begin : g_lane
    logic [AW-1:0] la;
    logic [BW-1:0] lb;
    logic signed [AW:0] ax;
    logic signed [BW:0] bx;
    logic signed [AW+BW+1:0] full;
    logic [PW-1:0] pv;
    assign la = op_a[l*AW +: AW];
    assign lb = op_b[l*BW +: BW];
    assign ax = {A_SGN ? la[AW-1] : 1'b0, la};
    assign bx = {B_SGN ? lb[BW-1] : 1'b0, lb};
    assign full = ax * bx;
    // The true min*min product needs one bit more than the product holds.
    assign pv = (A_SGN && B_SGN && la == A_MIN && lb == B_MIN) ?
                SAT_P : full[PW-1:0];
    assign prod[l*OW +: OW] = pv[PW-1 -: OW];
  end

  // Result line; its length sets the latency of each variant.
  always_comb begin
    res_d_nxt[0] = prod;
    res_v_nxt[0] = op_v;
    res_l_nxt[0] = op_l;
    res_u_nxt[0] = op_u;
    for (int i = 1; i < RL; i++) begin
      res_d_nxt[i] = res_d_r[i-1];
      res_v_nxt[i] = res_v_r[i-1];
      res_l_nxt[i] = res_l_r[i-1];
      res_u_nxt[i] = res_u_r[i-1];
    end
  end

  always_ff @(posedge MCLK or negedge ACTIVE_LOW_RESET) begin
    if (!ACTIVE_LOW_RESET) begin
      for (int i = 0; i < RL; i++) begin
        res_d_r[i] <= '0;
        res_u_r[i] <= '0;
      end
      res_v_r <= '0;
      res_l_r <= '0;
    end else if (CE) begin
      res_d_r <= res_d_nxt;
      res_u_r <= res_u_nxt;
      res_v_r <= res_v_nxt;
      res_l_r <= res_l_nxt;
    end
  end

  assign end_v = res_v_r[RL-1];
  assign end_l = res_l_r[RL-1];
  assign end_u = res_u_r[RL-1];
  assign end_d = res_d_r[RL-1];

  // Beats in flight must all fit in the FIFO, so the line never stalls.
  always_comb begin
    infl = op_cnt;
    for (int i = 0; i < RL; i++) begin
      infl = infl + FCW'(res_v_r[i]);
    end
    room = fifo_in_ready &&
           (({1'b0, fifo_cnt} + {1'b0, infl}) <
            (FCW+1)'(CMUL_FIFO_DEPTH));
  end

  generate
    if (IS_FC) begin : g_fc
      logic [FW-1:0] f_out;
      logic f_valid;
      cmul_fifo #(.WIDTH(FW), .DEPTH(CMUL_FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst_n(ACTIVE_LOW_RESET),
        .ce(CE),
        .in_valid(end_v),
        .in_ready(fifo_in_ready),
        .in_data({end_u, end_l, end_d}),
        .out_valid(f_valid),
        .out_ready(DOUT_TREADY),
        .out_data(f_out),
        .count(fifo_cnt)
      );
      // Valid is hidden while frozen so a beat is never taken twice.
      assign DOUT_TVALID = f_valid && CE;
      assign DOUT_TDATA = f_out[DW-1:0];
      assign DOUT_TLAST = f_out[DW];
      assign DOUT_TUSER = f_out[FW-1 -: UW];
    end else begin : g_nofc
      assign fifo_in_ready = 1'b1;
      assign fifo_cnt = '0;
      assign DOUT_TVALID = end_v;
      assign DOUT_TDATA = end_d;
      assign DOUT_TLAST = end_l;
      assign DOUT_TUSER = end_u;
    end
  endgenerate

  // Checking aids: lane 0 reference products and a run of enabled edges.
  logic [AW-1:0] ca;
  logic [BW-1:0] cb;
  logic [AW+BW-1:0] chk_u;
  logic signed [AW+BW-1:0] chk_s;
  logic [OW-1:0] u_top, s_top;
  logic [CMUL_RUN_W-1:0] run_r, run_nxt;
  assign ca = op_a[AW-1:0];
  assign cb = op_b[BW-1:0];
  assign chk_u = (AW+BW)'(ca) * (AW+BW)'(cb);
  assign chk_s = (AW+BW)'($signed(ca)) * (AW+BW)'($signed(cb));
  assign u_top = chk_u[PW-1 -: OW];
  assign s_top = chk_s[PW-1 -: OW];

  always_comb begin
    run_nxt = '0;
    if (CE) begin
      run_nxt = (run_r == CMUL_RUN_W'(NST)) ? run_r : run_r + CMUL_RUN_W'(1);
    end
  end

  always_ff @(posedge MCLK or negedge ACTIVE_LOW_RESET) begin
    if (!ACTIVE_LOW_RESET) begin
      run_r <= '0;
    end else begin
      run_r <= run_nxt;
    end
  end

  a_sat_min_min: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (A_SGN && B_SGN && CE && op_v && ca == A_MIN && cb == B_MIN)
    |=> res_d_r[0][OW-1:0] == SAT_TOP)
    else $error("min times min did not give positive full scale");

  a_unsigned_msb: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (!(A_SGN && B_SGN) && !A_SGN && !B_SGN && CE && op_v)
    |=> res_d_r[0][OW-1:0] == $past(u_top))
    else $error("unsigned product top bits wrong");

  a_signed_len: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (A_SGN && B_SGN && CE && op_v && !(ca == A_MIN && cb == B_MIN))
    |=> res_d_r[0][OW-1:0] == $past(s_top))
    else $error("signed product top bits wrong");

  a_line_latency: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (run_r == CMUL_RUN_W'(NST)) |-> end_v == $past(in_fire, NST))
    else $error("product left the line at the wrong cycle");

  a_last_align: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (run_r == CMUL_RUN_W'(NST) && $past(in_fire, NST))
    |-> end_l == $past(A_TLAST, NST))
    else $error("last flag out of step with its product");

  a_user_align: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (run_r == CMUL_RUN_W'(NST) && $past(in_fire, NST))
    |-> end_u == $past(A_TUSER, NST))
    else $error("user field out of step with its product");

  a_fc_no_drop: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (IS_FC && end_v) |-> fifo_in_ready)
    else $error("product reached a full buffer");

  a_fc_out_hold: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (IS_FC && DOUT_TVALID && !DOUT_TREADY) |=>
    (!CE || (DOUT_TVALID && DOUT_TDATA == $past(DOUT_TDATA))))
    else $error("stalled output beat changed");

  a_fc_buf_lat: assert property (@(posedge MCLK) disable iff (!ACTIVE_LOW_RESET)
    (IS_FC && CE && end_v && fifo_cnt == '0) |=> (DOUT_TVALID || !CE))
    else $error("buffer added more than one cycle");

endmodule : cmul_top

// file: verif/cmul_sink.sv
`timescale 1ns/1ps
module cmul_sink #(
  parameter int DW = 16,
  parameter int UW = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Stall request from the bench.
  input wire logic stall,
  // Product stream.
  input wire logic valid,
  input wire logic [DW-1:0] data,
  input wire logic last,
  input wire logic [UW-1:0] user,
  output logic ready
);
  logic ready_r;
  logic [DW+UW:0] got_q [$];

  // Ready follows the stall request one cycle late, like a registered sink.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= !stall;
    end
  end
  assign ready = ready_r;

  // A beat counts only at an edge where both valid and ready are high.
  always @(posedge clk) begin
    if (rst_n && valid && ready_r) begin
      got_q.push_back({last, user, data});
    end
  end
endmodule : cmul_sink

// file: verif/cmul_top_tb.sv
`timescale 1ns/1ps
module cmul_top_tb;
  import cmul_pkg::*;
  localparam int OPW = 8;
  localparam int NL = 2;
  localparam int UWB = 2;
  localparam int PLW = 32;
  localparam bit ON = 1'b1;
  localparam int FRZ = 5;
  logic mclk, active_low_reset, ce, va, vb, la, stall, ar, ov, ol, rdy;
  logic br, par, pbr, pv, pl, pu;
  logic [15:0] da, db, od;
  logic [1:0] ua, ou;
  logic [31:0] pd;
  int mismatches, checks;
  logic [18:0] exp_q [$];

  cmul_top #(.VARIANT(CMUL_STREAM_FC), .A_W(OPW), .B_W(OPW), .A_SGN(ON),
    .B_SGN(ON), .OUT_W(OPW), .LANES(NL), .USER_W(UWB)) dut (
    .MCLK(mclk), .ACTIVE_LOW_RESET(active_low_reset), .CE(ce), .A_TDATA(da), .A_TVALID(va),
    .A_TREADY(ar), .A_TLAST(la), .A_TUSER(ua), .B_TDATA(db),
    .B_TVALID(vb), .B_TREADY(br), .DOUT_TDATA(od), .DOUT_TVALID(ov),
    .DOUT_TREADY(rdy), .DOUT_TLAST(ol), .DOUT_TUSER(ou));
  cmul_top #(.A_W(OPW), .B_W(OPW), .OUT_W(PLW), .LANES(NL),
    .LATCH_IN(ON)) dut_plain (
    .MCLK(mclk), .ACTIVE_LOW_RESET(active_low_reset), .CE(ce), .A_TDATA(da), .A_TVALID(va),
    .A_TREADY(par), .A_TLAST(la), .A_TUSER(ua[0]), .B_TDATA(db),
    .B_TVALID(vb), .B_TREADY(pbr), .DOUT_TDATA(pd), .DOUT_TVALID(pv),
    .DOUT_TREADY(rdy), .DOUT_TLAST(pl), .DOUT_TUSER(pu));
  cmul_sink #(.DW(NL * OPW), .UW(UWB)) sink (.clk(mclk), .rst_n(active_low_reset),
    .stall(stall), .valid(ov), .data(od), .last(ol), .user(ou),
    .ready(rdy));

  function automatic logic [7:0] smul(logic [7:0] a, logic [7:0] b);
    logic signed [15:0] p;
    p = $signed(a) * $signed(b);
    if (a == 8'h80 && b == 8'h80) begin
      p = 16'h3FFF;
    end
    return p[14:7];
  endfunction : smul

  function automatic logic [31:0] uexp(logic [15:0] a, logic [15:0] b);
    logic [15:0] p1, p0;
    p1 = a[15:8] * b[15:8];
    p0 = a[7:0] * b[7:0];
    return {p1, p0};
  endfunction : uexp

  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_num(int got, int exp);
    checks++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got,
        exp);
    end
  endtask : cmp_num

  // Offers one joined beat; returns at the taking edge or after 9 cycles.
  task automatic send(logic [15:0] a, logic [15:0] b, logic [2:0] lu,
                      output bit ok);
    int n;
    n = 0;
    da <= a;
    db <= b;
    {la, ua} <= lu;
    va <= 1'b1;
    vb <= 1'b1;
    @(negedge mclk);
    while (ar !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    ok = (ar === 1'b1);
    cmp_val(32'(br), 32'(ok));
    @(posedge mclk);
    if (ok) begin
      exp_q.push_back({lu, smul(a[15:8], b[15:8]), smul(a[7:0], b[7:0])});
    end
  endtask : send

  task automatic drain(int n);
    int w;
    w = 0;
    va <= 1'b0;
    vb <= 1'b0;
    while (sink.got_q.size() < n && w < 200) begin
      @(posedge mclk);
      w++;
    end
    @(posedge mclk);
    cmp_num(sink.got_q.size(), n);
    while (sink.got_q.size() > 0 && exp_q.size() > 0) begin
      cmp_val(32'(sink.got_q.pop_front()), 32'(exp_q.pop_front()));
    end
    sink.got_q.delete();
    exp_q.delete();
  endtask : drain

  task automatic t_products();
    logic [7:0] tab [6] = '{8'h80, 8'h7F, 8'hFF, 8'h00, 8'h01, 8'hC3};
    bit ok;
    for (int i = 0; i < 6; i++) begin
      send({tab[i], tab[5-i]}, {tab[i], tab[i]}, 3'(i), ok);
    end
    drain(6);
  endtask : t_products

  task automatic t_latency();
    int n;
    bit ok;
    n = 0;
    send(16'h0203, 16'h0405, 3'h5, ok);
    va <= 1'b0;
    vb <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (ov !== 1'b1 && n < 20);
    cmp_num(n, CMUL_FC_LAT);
    @(posedge mclk);
    drain(1);
  endtask : t_latency

  // Freezes the block while a product is about to leave the buffer.
  task automatic t_freeze();
    int n;
    bit ok;
    n = 0;
    send(16'h80C3, 16'h807F, 3'h6, ok);
    va <= 1'b0;
    vb <= 1'b0;
    repeat (CMUL_FC_LAT - 1) @(posedge mclk);
    ce <= 1'b0;
    va <= 1'b1;
    vb <= 1'b1;
    repeat (FRZ) begin
      @(negedge mclk);
      cmp_val(32'({ov, ar, br, par, pbr, pv}), 32'h1);
      cmp_val(pd, uexp(16'h80C3, 16'h807F));
    end
    @(posedge mclk);
    ce <= 1'b1;
    va <= 1'b0;
    vb <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (ov !== 1'b1 && n < 20);
    cmp_num(n, 1);
    @(posedge mclk);
    drain(1);
  endtask : t_freeze

  task automatic t_fill();
    int acc;
    bit ok;
    acc = 0;
    ok = 1'b1;
    stall <= 1'b1;
    @(posedge mclk);
    while (ok && acc < 20) begin
      send({8'(acc), 8'h81}, {8'h03, 8'(acc)}, 3'h2, ok);
      if (ok) begin
        acc++;
      end
    end
    cmp_num(acc, CMUL_FIFO_DEPTH);
    stall <= 1'b0;
    drain(16);
  endtask : t_fill

  task automatic t_plain();
    logic [15:0] a, b;
    logic [31:0] e [$];
    for (int i = 0; i < 10; i++) begin
      a = {8'(200 + i), 8'(i * 29)};
      b = {8'(i * 31), 8'(255 - i)};
      da <= a;
      db <= b;
      la <= i[1];
      ua <= 2'(i);
      e.push_back(uexp(a, b));
      @(negedge mclk);
      if (i >= 2) begin
        cmp_val(pd, e[i-2]);
        cmp_val(32'({pv, pl, pu}), 32'({1'b1, 2'(i - 2)}));
      end
      @(posedge mclk);
    end
  endtask : t_plain

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    active_low_reset = 1'b0;
    ce = 1'b1;
    va = 1'b0;
    vb = 1'b0;
    la = 1'b0;
    ua = 2'h0;
    da = 16'h0;
    db = 16'h0;
    stall = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge mclk);
    active_low_reset <= 1'b1;
    @(posedge mclk);
    t_products();
    t_latency();
    t_freeze();
    t_fill();
    t_plain();
    final_report();
  end
endmodule : cmul_top_tb
